// ==== rtl/dkr_pkg.sv ====
/*
 * Constants for the drive register bank: byte offsets, field positions,
 * function codes, error flag slots and timing.
 * Assumes a 50 MHz ref_clk and 16-bit drive registers.
 */
package dkr_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_CTRL1 = 6'h00;
    localparam logic [5:0] OFS_STATUS = 6'h04;
    localparam logic [5:0] OFS_FAULT_A = 6'h08;
    localparam logic [5:0] OFS_DIAG = 6'h0c;
    localparam logic [5:0] OFS_ATTN = 6'h10;
    localparam logic [5:0] OFS_SECT_TRK = 6'h14;
    localparam logic [5:0] OFS_KIND = 6'h18;
    localparam logic [5:0] OFS_ROTPOS = 6'h1c;
    localparam logic [5:0] OFS_SERIAL = 6'h20;
    localparam logic [5:0] OFS_FMT_CTL = 6'h24;
    localparam logic [5:0] OFS_TCYL = 6'h28;
    localparam logic [5:0] OFS_PCYL = 6'h2c;
    localparam logic [5:0] OFS_FAULT_B = 6'h30;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GO_BIT = 0;
    localparam int STS_ATTN_BIT = 15;
    localparam int STS_ES_BIT = 14;
    localparam int FC_CMOD_BIT = 15;
    localparam int FC_MOVE_BIT = 14;
    localparam int FC_FMT16_BIT = 12;
    localparam int FC_ECCI_BIT = 11;
    localparam int FC_HCI_BIT = 10;
    localparam int KIND_MOVHEAD_BIT = 13;
    localparam int KIND_DUAL_BIT = 11;
    localparam int FLT_B_PROG_BIT = 15;
    localparam int FLT_B_ROM_BIT = 14;
    // ------------------------------------------------------------
    // Function codes, go bit included
    // ------------------------------------------------------------
    localparam logic [5:0] CMD_NOP1 = 6'h01;
    localparam logic [5:0] CMD_SEEK = 6'h05;
    localparam logic [5:0] CMD_RECAL = 6'h07;
    localparam logic [5:0] CMD_DCLR = 6'h09;
    localparam logic [5:0] CMD_RELEASE = 6'h0b;
    localparam logic [5:0] CMD_OFFSET = 6'h0d;
    localparam logic [5:0] CMD_RTC = 6'h0f;
    localparam logic [5:0] CMD_PRESET = 6'h11;
    localparam logic [5:0] CMD_NOP2 = 6'h13;
    localparam logic [5:0] CMD_SEARCH = 6'h19;
    localparam logic [5:0] CMD_DIAG = 6'h1d;
    localparam logic [5:0] CMD_WCHK = 6'h29;
    localparam logic [5:0] CMD_WCHKHD = 6'h2b;
    localparam logic [5:0] CMD_WRITE = 6'h31;
    localparam logic [5:0] CMD_FMTTRK = 6'h33;
    localparam logic [5:0] CMD_WRDESC = 6'h35;
    localparam logic [5:0] CMD_READ = 6'h39;
    localparam logic [5:0] CMD_RDHD = 6'h3b;
    localparam logic [5:0] CMD_RDDESC = 6'h3d;
    // ------------------------------------------------------------
    // Error flag slots (0-7 are fault_a bits 0-7)
    // ------------------------------------------------------------
    localparam int NFLAGS = 10;
    localparam int F_ILF = 0;
    localparam int F_ILR = 1;
    localparam int F_RMR = 2;
    localparam int F_PAR = 3;
    localparam int F_FMT = 4;
    localparam int F_WCF = 5;
    localparam int F_ECH = 6;
    localparam int F_HCE = 7;
    localparam int F_ROM = 8;
    localparam int F_PRG = 9;
    // ------------------------------------------------------------
    // Geometry, layout and timing
    // ------------------------------------------------------------
    localparam logic [5:0] LAST_SECTOR = 6'h31;
    localparam logic [8:0] DESC_BASE = 9'h080;
    localparam logic [8:0] DESC_EXTRA = 9'h0d8;
    localparam logic [8:0] KIND_CODE = 9'h0a5;  // Arbitrary value
    localparam logic [15:0] SERIAL_BCD = 16'h1234;  // Arbitrary value
    localparam int CLK_PERIOD_NS = 20;
    localparam int WCLK_GAP_NS = 1000;
    localparam int WCLK_GAP_CYC = WCLK_GAP_NS / CLK_PERIOD_NS;
endpackage

// ==== rtl/dkr_flag.sv ====
/*
 * One sticky error flag: a set wins over a clear in the same cycle.
 * Assumes ref_clk and synchronous active-low resetn.
 */
module dkr_flag (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic set,
    input wire logic clr,
    output logic flag_q
);
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= set | (flag_q & ~clr);
        end
    end
endmodule

// ==== rtl/dkr_wclk_watch.sv ====
/*
 * Watches for write clock pulses while a write is under way.
 * Assumes write_active and write_clk are synchronous to ref_clk.
 */
module dkr_wclk_watch
    import dkr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic write_active,
    input wire logic write_clk,
    output logic fail
);
    logic [7:0] gap_q;

    // Counts idle cycles since the last write clock of this write
    always_ff @(posedge ref_clk) begin
        if (!resetn || !write_active || write_clk) begin
            gap_q <= 8'h00;
        end else if (gap_q != 8'(WCLK_GAP_CYC)) begin
            gap_q <= gap_q + 8'h01;
        end
    end

    // One pulse when the gap first reaches the limit
    assign fail = write_active && !write_clk &&
                  (gap_q == 8'(WCLK_GAP_CYC - 1));
endmodule

// ==== rtl/dkr_regs.sv ====
/*
 * Drive register bank: control word, error flags, attention summary,
 * sector/track, kind, look-ahead, serial, format control, cylinders.
 * Assumes a register port synchronous to ref_clk with one-cycle read
 * and write strobes; mechanics report through plain event inputs.
 */
module dkr_regs
    import dkr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic bus_init,
    input wire logic [5:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic ctl_par_err,
    input wire logic [7:0] drive_atn,
    input wire logic hdr_cmp_fail,
    input wire logic ecc_hard,
    input wire logic write_active,
    input wire logic write_clk,
    input wire logic data_par_err,
    input wire logic hdr_fmt_valid,
    input wire logic hdr_fmt16,
    input wire logic rom_par_err,
    input wire logic rom_err_clr,
    input wire logic sector_done,
    input wire logic op_done,
    input wire logic [5:0] sector_under_head,
    input wire logic [9:0] cyl_position,
    input wire logic heads_moving,
    input wire logic dual_port,
    output logic [15:0] reg_rdata_q,
    output logic go_q,
    output logic [4:0] fn_code_q,
    output logic cmd_start_q,
    output logic error_summary_q,
    output logic device_check_q,
    output logic ecc_inhibit_q,
    output logic full_field_q,
    output logic fmt16_q,
    output logic [8:0] desc_offset_q,
    output logic [9:0] target_cyl_q,
    output logic [5:0] sector_q,
    output logic [5:0] track_q
);
    // ------------------------------------------------------------
    // Address decode and write qualification
    // ------------------------------------------------------------
    logic addr_legal;
    logic wr_refused;
    logic wr_ok;
    logic cmd_load;
    logic cmd_legal;
    logic cmd_desc;
    logic cmd_dclr;
    logic cmd_accept;
    logic [5:0] cmd_val;
    logic [NFLAGS-1:0] flag_set;
    logic [NFLAGS-1:0] flag_clr;
    logic [NFLAGS-1:0] flag_q;
    logic wclk_fail;
    logic [7:0] attn_q;
    logic [7:0] attn_prev_q;
    logic [15:0] diag_q;
    logic cmod_q;
    logic move_q;
    logic [9:0] pres_cyl_q;

    always_comb begin
        unique case (reg_addr)
            OFS_CTRL1, OFS_STATUS, OFS_FAULT_A, OFS_DIAG, OFS_ATTN,
            OFS_SECT_TRK, OFS_KIND, OFS_ROTPOS, OFS_SERIAL,
            OFS_FMT_CTL, OFS_TCYL, OFS_PCYL, OFS_FAULT_B:
                addr_legal = 1'b1;
            default: addr_legal = 1'b0;
        endcase
    end

    // Only attention summary may be written while an operation runs
    assign wr_refused = reg_wr && addr_legal && go_q &&
                        (reg_addr != OFS_ATTN);
    // A write with a control parity fault is dropped, not stored
    assign wr_ok = reg_wr && addr_legal && !ctl_par_err && !wr_refused;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    assign cmd_val = reg_wdata[5:0];
    assign cmd_load = wr_ok && (reg_addr == OFS_CTRL1) &&
                      reg_wdata[GO_BIT];
    always_comb begin
        unique case (cmd_val)
            CMD_NOP1, CMD_SEEK, CMD_RECAL, CMD_DCLR, CMD_RELEASE,
            CMD_OFFSET, CMD_RTC, CMD_PRESET, CMD_NOP2, CMD_SEARCH,
            CMD_DIAG, CMD_WCHK, CMD_WCHKHD, CMD_WRITE, CMD_FMTTRK,
            CMD_WRDESC, CMD_READ, CMD_RDHD, CMD_RDDESC:
                cmd_legal = 1'b1;
            default: cmd_legal = 1'b0;
        endcase
    end
    assign cmd_desc = (cmd_val == CMD_FMTTRK) ||
                      (cmd_val == CMD_WRDESC) ||
                      (cmd_val == CMD_RDDESC);
    assign cmd_dclr = cmd_load && (cmd_val == CMD_DCLR);
    // Drive clear completes at once, so it never raises go
    assign cmd_accept = cmd_load && cmd_legal && !cmd_dclr &&
                        !error_summary_q &&
                        !(cmd_desc && !cmod_q);

    // ------------------------------------------------------------
    // Error flags
    // ------------------------------------------------------------
    dkr_wclk_watch u_wclk (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .write_active(write_active),
        .write_clk(write_clk),
        .fail(wclk_fail)
    );

    always_comb begin
        flag_set = '0;
        flag_set[F_HCE] = hdr_cmp_fail;
        flag_set[F_ECH] = ecc_hard;
        flag_set[F_WCF] = wclk_fail;
        flag_set[F_FMT] = hdr_fmt_valid && (hdr_fmt16 != fmt16_q);
        flag_set[F_PAR] = (data_par_err && write_active) ||
                          (reg_wr && ctl_par_err);
        flag_set[F_RMR] = wr_refused;
        flag_set[F_ILR] = (reg_wr || reg_rd) && !addr_legal;
        flag_set[F_ILF] = cmd_load && !cmd_legal;
        flag_set[F_ROM] = rom_par_err;
        flag_set[F_PRG] = cmd_load && cmd_legal && cmd_desc &&
                          !cmod_q;
        flag_clr = {NFLAGS{bus_init || cmd_dclr}};
        flag_clr[F_ROM] = bus_init || cmd_dclr || rom_err_clr;
    end
    genvar gi;
    generate
        for (gi = 0; gi < NFLAGS; gi++) begin : g_flag
            dkr_flag u_flag (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .set(flag_set[gi]),
                .clr(flag_clr[gi]),
                .flag_q(flag_q[gi])
            );
        end
    endgenerate
    // Summary trails the flags by one cycle
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            error_summary_q <= 1'b0;
            device_check_q <= 1'b0;
        end else begin
            error_summary_q <= |flag_q;
            device_check_q <= flag_q[F_ROM];
        end
    end

    // ------------------------------------------------------------
    // Control word and go
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn || bus_init) begin
            go_q <= 1'b0;
            fn_code_q <= 5'h00;
            cmd_start_q <= 1'b0;
        end else begin
            cmd_start_q <= cmd_accept;
            if (cmd_accept) begin
                go_q <= 1'b1;
                fn_code_q <= cmd_val[5:1];
            end else if (op_done) begin
                go_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Attention summary
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        // Tracked through bus_init so a held line is no fresh rise
        attn_prev_q <= resetn ? drive_atn : 8'h00;
        if (!resetn || bus_init) begin
            attn_q <= 8'h00;
        end else begin
            // Rise sets; drive release or a written one clears
            attn_q <= drive_atn & ((drive_atn & ~attn_prev_q) |
                      (attn_q & ~((wr_ok && reg_addr == OFS_ATTN) ?
                      reg_wdata[7:0] : 8'h00)));
        end
    end

    // ------------------------------------------------------------
    // Sector and track address
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sector_q <= 6'h00;
            track_q <= 6'h00;
        end else if (wr_ok && reg_addr == OFS_SECT_TRK) begin
            sector_q <= reg_wdata[5:0];
            track_q <= reg_wdata[13:8];
        end else if (sector_done) begin
            if (sector_q == LAST_SECTOR) begin
                sector_q <= 6'h00;
                track_q <= track_q + 6'h01;
            end else begin
                sector_q <= sector_q + 6'h01;
            end
        end
    end

    // ------------------------------------------------------------
    // Format control, cylinders, diagnostics
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cmod_q <= 1'b0;
            move_q <= 1'b0;
            fmt16_q <= 1'b0;
            ecc_inhibit_q <= 1'b0;
            full_field_q <= 1'b0;
            desc_offset_q <= DESC_BASE;
        end else if (wr_ok && reg_addr == OFS_FMT_CTL) begin
            cmod_q <= reg_wdata[FC_CMOD_BIT];
            move_q <= reg_wdata[FC_MOVE_BIT];
            fmt16_q <= reg_wdata[FC_FMT16_BIT];
            ecc_inhibit_q <= reg_wdata[FC_ECCI_BIT];
            full_field_q <= reg_wdata[FC_HCI_BIT];
            desc_offset_q <= reg_wdata[FC_MOVE_BIT] ?
                             DESC_BASE + DESC_EXTRA : DESC_BASE;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            target_cyl_q <= 10'h000;
            diag_q <= 16'h0000;
        end else if (wr_ok) begin
            if (reg_addr == OFS_TCYL) begin
                target_cyl_q <= reg_wdata[9:0];
            end
            if (reg_addr == OFS_DIAG) begin
                diag_q <= reg_wdata;
            end
        end
    end
    // Held while seeking so software never sees a moving count
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            pres_cyl_q <= 10'h000;
        end else if (!heads_moving) begin
            pres_cyl_q <= cyl_position;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            reg_rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata_q <= 16'h0000;
            unique case (reg_addr)
                OFS_CTRL1: reg_rdata_q <= {10'h000, fn_code_q, go_q};
                OFS_STATUS: reg_rdata_q[STS_ATTN_BIT:STS_ES_BIT] <=
                    {error_summary_q, error_summary_q};
                OFS_FAULT_A: reg_rdata_q[7:0] <= flag_q[F_HCE:F_ILF];
                OFS_DIAG: reg_rdata_q <= diag_q;
                OFS_ATTN: reg_rdata_q[7:0] <= attn_q;
                OFS_SECT_TRK: reg_rdata_q <= {2'b00, track_q, 2'b00,
                                              sector_q};
                OFS_KIND: begin
                    reg_rdata_q[KIND_MOVHEAD_BIT] <= 1'b1;
                    reg_rdata_q[KIND_DUAL_BIT] <= dual_port;
                    reg_rdata_q[8:0] <= KIND_CODE;
                end
                OFS_ROTPOS: reg_rdata_q[12:6] <=
                    {1'b0, sector_under_head};
                OFS_SERIAL: reg_rdata_q <= SERIAL_BCD;
                OFS_FMT_CTL: reg_rdata_q[FC_CMOD_BIT:FC_HCI_BIT] <=
                    {cmod_q, move_q, 1'b0, fmt16_q, ecc_inhibit_q,
                     full_field_q};
                OFS_TCYL: reg_rdata_q[9:0] <= target_cyl_q;
                OFS_PCYL: reg_rdata_q[9:0] <= pres_cyl_q;
                OFS_FAULT_B: reg_rdata_q[FLT_B_PROG_BIT:FLT_B_ROM_BIT] <=
                    flag_q[F_PRG:F_ROM];
                default: reg_rdata_q <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    hdr_cmp_flag_a: assert property (@(posedge ref_clk)
        disable iff (!resetn) hdr_cmp_fail |=> flag_q[F_HCE])
        else $error("header compare flag not set");
    refused_write_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        (reg_wr && go_q && addr_legal && reg_addr != OFS_ATTN)
        |=> flag_q[F_RMR] && $stable(target_cyl_q))
        else $error("write during go not refused");
    illegal_reg_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        (reg_rd && !addr_legal) |=> flag_q[F_ILR] ##1 error_summary_q)
        else $error("illegal register not flagged");
    drive_clear_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        (cmd_dclr && flag_set == '0) |=> flag_q == '0 ##1
        !error_summary_q)
        else $error("drive clear left flags set");
    prog_error_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        (cmd_load && cmd_val == CMD_FMTTRK && !cmod_q)
        |=> flag_q[F_PRG] && !cmd_start_q)
        else $error("format without modifier accepted");
    summary_block_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        (error_summary_q && cmd_load && !go_q) |=> !cmd_start_q)
        else $error("command taken under error summary");
    go_done_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        (go_q && op_done && !cmd_accept) |=> !go_q)
        else $error("go not cleared at end of operation");
    sector_wrap_a: assert property (@(posedge ref_clk)
        disable iff (!resetn)
        (sector_done && sector_q == LAST_SECTOR && !wr_ok)
        |=> sector_q == 6'h00 && track_q == $past(track_q) + 6'h01)
        else $error("track not advanced past last sector");
    attn_w1c_a: assert property (@(posedge ref_clk)
        disable iff (!resetn || bus_init)
        (wr_ok && reg_addr == OFS_ATTN && attn_q[0] && drive_atn[0]
         && !reg_wdata[0]) |=> attn_q[0])
        else $error("attention bit lost on zero write");
endmodule

// ==== bench/dkr_ctl_model.sv ====
/*
 * Controller-side write clock source for the drive register bench.
 * Assumes its inputs change at the falling edge of ref_clk.
 */
module dkr_ctl_model (
    input wire logic ref_clk,
    input wire logic write_active,
    input wire logic stall,
    output logic write_clk
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div = 2'h0;
    initial write_clk = 1'b0;
    // Pulse every fourth cycle; stall starves the drive of clocks
    always @(negedge ref_clk) begin
        div <= div + 2'h1;
        write_clk <= write_active && !stall && div == 2'h3;
    end
endmodule

// ==== bench/dkr_bench.sv ====
/*
 * Self-checking bench for the drive register bank.
 * Assumes dkr_pkg, dkr_regs and dkr_ctl_model are compiled first.
 */
module disk_drive_error_and_address_regs_bench
    import dkr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0, resetn = 1'b0, bus_init = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, ctl_par_err = 1'b0;
    logic hdr_cmp_fail = 1'b0, ecc_hard = 1'b0, write_active = 1'b0;
    logic data_par_err = 1'b0, hdr_fmt_valid = 1'b0, hdr_fmt16 = 1'b0;
    logic rom_par_err = 1'b0, rom_err_clr = 1'b0, sector_done = 1'b0;
    logic op_done = 1'b0, heads_moving = 1'b0, dual_port = 1'b0;
    logic stall = 1'b0, write_clk, go_q, cmd_start_q, error_summary_q;
    logic device_check_q, ecc_inhibit_q, full_field_q, fmt16_q;
    logic [5:0] reg_addr = 6'h00, sector_under_head = 6'h00;
    logic [5:0] sector_q, track_q;
    logic [7:0] drive_atn = 8'h00;
    logic [8:0] desc_offset_q;
    logic [9:0] cyl_position = 10'h000, target_cyl_q, v, p = 10'h000;
    logic [4:0] fn_code_q;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata_q, a;
    int miscompares = 0, tests_run = 0, cycles = 0, starts = 0;

    dkr_regs i_dut (.ref_clk, .resetn, .bus_init, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .ctl_par_err, .drive_atn, .hdr_cmp_fail,
        .ecc_hard, .write_active, .write_clk, .data_par_err, .hdr_fmt_valid,
        .hdr_fmt16, .rom_par_err, .rom_err_clr, .sector_done, .op_done,
        .sector_under_head, .cyl_position, .heads_moving, .dual_port,
        .reg_rdata_q, .go_q, .fn_code_q, .cmd_start_q, .error_summary_q,
        .device_check_q, .ecc_inhibit_q, .full_field_q, .fmt16_q,
        .desc_offset_q, .target_cyl_q, .sector_q, .track_q);
    dkr_ctl_model i_ctl (.ref_clk, .write_active, .stall, .write_clk);

    always #10 ref_clk = ~ref_clk;
    // Run needs under a thousand cycles; this only cuts a hang
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            give_verdict();
        end
    end

    // Accepted commands, counted mid-cycle where the pulse stands
    always @(negedge ref_clk) if (cmd_start_q === 1'b1) starts++;

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic xfer(input logic w, input logic [5:0] ad,
                        input logic [15:0] d);
        reg_addr = ad;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        cyc(1);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        cyc(2);
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
        cyc(2);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdc(input string what, input logic [5:0] ad,
                       input logic [15:0] exp);
        xfer(1'b0, ad, 16'h0000);
        chk(what, exp, reg_rdata_q);
    endtask
    // Exactly one flag up, summary shown, then drive clear empties it
    task automatic flag_seen(input int b);
        cyc(2);
        rdc("fault_a", OFS_FAULT_A, 16'h0001 << b);
        rdc("status", OFS_STATUS, 16'hc000);
        xfer(1'b1, OFS_CTRL1, {10'h000, CMD_DCLR});
        rdc("cleared", OFS_FAULT_A, 16'h0000);
    endtask
    function automatic logic [15:0] kind_exp(input logic dual);
        return {2'b00, 1'b1, 1'b0, dual, 2'b00, KIND_CODE};
    endfunction
    function automatic logic [15:0] next_addr(input logic [15:0] d);
        if (d[5:0] == LAST_SECTOR) return {2'b00, d[13:8] + 6'h01, 8'h00};
        return d + 16'h0001;
    endfunction
    task automatic give_verdict();
        if (miscompares == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        a = 16'($urandom(32'h6dcc));
        cyc(12);
        resetn = 1'b1;
        cyc(1);
        dual_port = a[0];
        rdc("kind", OFS_KIND, kind_exp(a[0]));
        rdc("serial", OFS_SERIAL, SERIAL_BCD);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 10'h275 : 10'($urandom_range(629));
            sector_under_head = 6'($urandom_range(49));
            heads_moving = 1'b1;
            cyl_position = v;
            xfer(1'b1, OFS_TCYL, {6'h00, v});
            rdc("pcyl_hold", OFS_PCYL, {6'h00, p});
            heads_moving = 1'b0;
            cyc(2);
            rdc("tcyl", OFS_TCYL, {6'h00, v});
            rdc("pcyl", OFS_PCYL, {6'h00, v});
            rdc("la", OFS_ROTPOS, {4'h0, sector_under_head, 6'h00});
            p = v;
        end
        for (int i = 0; i < 3; i++) begin
            a = {2'b00, 6'($urandom_range(30)), 8'h00};
            a[5:0] = (i == 0) ? LAST_SECTOR : 6'($urandom_range(49));
            xfer(1'b1, OFS_SECT_TRK, a);
            pulse(sector_done);
            rdc("da", OFS_SECT_TRK, next_addr(a));
        end
        drive_atn = 8'h81;
        cyc(2);
        xfer(1'b1, OFS_ATTN, 16'h0000);
        rdc("attn", OFS_ATTN, 16'h0081);
        xfer(1'b1, OFS_ATTN, 16'h0001);
        rdc("attn", OFS_ATTN, 16'h0080);
        drive_atn = 8'h00;
        cyc(2);
        rdc("attn", OFS_ATTN, 16'h0000);
        pulse(hdr_cmp_fail);
        flag_seen(F_HCE);
        pulse(ecc_hard);
        flag_seen(F_ECH);
        hdr_fmt16 = 1'b1;
        pulse(hdr_fmt_valid);
        flag_seen(F_FMT);
        write_active = 1'b1;
        cyc(60);
        pulse(data_par_err);
        flag_seen(F_PAR);
        stall = 1'b1;
        cyc(60);
        stall = 1'b0;
        write_active = 1'b0;
        flag_seen(F_WCF);
        ctl_par_err = 1'b1;
        xfer(1'b1, OFS_TCYL, 16'h0000);
        ctl_par_err = 1'b0;
        flag_seen(F_PAR);
        xfer(1'b1, OFS_FMT_CTL, 16'h5c00);
        chk("fmt", {4'h0, 3'b111, DESC_BASE + DESC_EXTRA},
            {4'h0, ecc_inhibit_q, full_field_q, fmt16_q, desc_offset_q});
        pulse(hdr_fmt_valid);
        rdc("fault_a", OFS_FAULT_A, 16'h0000);
        xfer(1'b1, OFS_CTRL1, {10'h000, CMD_WRITE});
        chk("go", {11'h001, CMD_WRITE[5:1]}, {10'h000, go_q, fn_code_q});
        xfer(1'b1, OFS_TCYL, 16'h0007);
        chk("tcyl", {6'h00, v}, {6'h00, target_cyl_q});
        pulse(op_done);
        chk("go", 16'h0000, {15'h0000, go_q});
        flag_seen(F_RMR);
        xfer(1'b1, OFS_CTRL1, 16'h0003);
        flag_seen(F_ILF);
        xfer(1'b0, 6'h34, 16'h0000);
        cyc(2);
        xfer(1'b1, OFS_CTRL1, {10'h000, CMD_SEEK});
        chk("go", 16'h0000, {15'h0000, go_q});
        flag_seen(F_ILR);
        xfer(1'b1, OFS_FMT_CTL, 16'h0000);
        xfer(1'b1, OFS_CTRL1, {10'h000, CMD_FMTTRK});
        rdc("fault_b", OFS_FAULT_B, 16'h8000);
        chk("go", 16'h0000, {15'h0000, go_q});
        drive_atn = 8'h02;
        cyc(2);
        pulse(bus_init);
        rdc("fault_b", OFS_FAULT_B, 16'h0000);
        rdc("attn", OFS_ATTN, 16'h0000);
        drive_atn = 8'h00;
        xfer(1'b1, OFS_FMT_CTL, 16'h8000);
        xfer(1'b1, OFS_CTRL1, {10'h000, CMD_RDDESC});
        chk("go", 16'h0001, {15'h0000, go_q});
        pulse(op_done);
        pulse(rom_par_err);
        chk("dev_chk", 16'h0001, {15'h0000, device_check_q});
        rdc("fault_b", OFS_FAULT_B, 16'h4000);
        pulse(rom_err_clr);
        rdc("fault_b", OFS_FAULT_B, 16'h0000);
        chk("starts", 16'h0002, 16'(starts));
        give_verdict();
    end
endmodule
